//--- rtl/pss_pkg.sv
// constants and types for the protection startup sequencer
package pss_pkg;
  // clock rate
  localparam int unsigned CLK_MHZ     = 200;
  // sequencing times in microseconds
  localparam int unsigned T_CORE_US   = 700;
  localparam int unsigned T_ADDR_US   = 150;
  localparam int unsigned T_CHECK_US  = 2200000;
  localparam int unsigned T_PG_US     = 6000;
  localparam int unsigned T_DLY1_US   = 2500;
  localparam int unsigned T_DLY2_US   = 12500;
  localparam int unsigned T_DLY3_US   = 22500;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_STATUS  = 8'h04;
  // control field positions
  localparam int unsigned CTRL_DLY_LSB = 0;
  localparam int unsigned CTRL_THR_LSB = 2;
  localparam int unsigned CTRL_RESTART = 8;
  // status field positions
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_FLT_LSB   = 8;
  localparam int unsigned ST_PG        = 16;
  localparam int unsigned ST_HYST      = 17;
  localparam int unsigned ST_ADDR_DONE = 18;
  // reset values
  localparam logic [1:0]  DLY_SEL_RST = 2'h0;
  localparam logic [1:0]  THR_SEL_RST = 2'h2;

  typedef enum logic [3:0] {
    ST_CORE,
    ST_ADDR,
    ST_EN_WAIT,
    ST_DELAY,
    ST_CHECK,
    ST_RAMP,
    ST_PG_WAIT,
    ST_RUN,
    ST_FAULT
  } pss_state_e;
endpackage

//--- rtl/pss_sequencer.sv
// startup sequencer and latched fault control with apb registers
`timescale 1ns/1ps
module pss_sequencer #(
  parameter int unsigned CORE_CYC  = pss_pkg::T_CORE_US * pss_pkg::CLK_MHZ,
  parameter int unsigned ADDR_CYC  = pss_pkg::T_ADDR_US * pss_pkg::CLK_MHZ,
  parameter int unsigned CHECK_CYC = pss_pkg::T_CHECK_US * pss_pkg::CLK_MHZ,
  parameter int unsigned PG_CYC    = pss_pkg::T_PG_US * pss_pkg::CLK_MHZ,
  parameter int unsigned DLY1_CYC  = pss_pkg::T_DLY1_US * pss_pkg::CLK_MHZ,
  parameter int unsigned DLY2_CYC  = pss_pkg::T_DLY2_US * pss_pkg::CLK_MHZ,
  parameter int unsigned DLY3_CYC  = pss_pkg::T_DLY3_US * pss_pkg::CLK_MHZ
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // analog monitors
  input  wire logic        core_undervoltage,
  input  wire logic        boost_undervoltage,
  input  wire logic        enable_undervoltage_input,
  input  wire logic        address_resistor_ok,
  input  wire logic        limit_resistor_bad,
  input  wire logic [2:0]  output_below_check_threshold,
  input  wire logic        ss_cap_below_threshold,
  input  wire logic        ramp_done,
  input  wire logic        current_above_upper,
  input  wire logic        current_below_lower,
  // power stage controls
  output logic             pass_switch_on,
  output logic             output_discharge_en,
  output logic             ss_discharge_en,
  output logic             ss_charge_en,
  output logic             power_good_output,
  // address select pin, reused as hysteresis flag
  input  wire logic        address_select_pin_i,
  output logic             address_select_pin_o,
  output logic             address_select_pin_oe,
  // latched fault line, active low, two-way
  input  wire logic        fault_line_i,
  output logic             fault_line_o,
  output logic             fault_line_oe,
  // bus alert, active low open drain
  output logic             bus_alert_o,
  output logic             bus_alert_oe
);

  pss_pkg::pss_state_e state_q, state_d;
  logic [31:0] cnt_q, cnt_d, dly_cyc;
  logic [1:0]  dly_sel_q, thr_sel_q;
  logic        restart_q, keep, leave;
  logic        short_q, ssd_q, moderate_limit_resistor_pin_q, addr_q, core_q, ext_q;
  logic        hyst_q, addr_done_q, pg_q;
  logic        vout_low, check_end, own_fault, stop, clr_lo, post_core;
  logic        wr, rd_setup;

  assign vout_low  = output_below_check_threshold[(thr_sel_q == 2'h3) ?
                     2'h2 : thr_sel_q];
  assign check_end = (state_q == pss_pkg::ST_CHECK) && (cnt_q == 32'h0);
  assign own_fault = short_q | ssd_q | moderate_limit_resistor_pin_q | addr_q | core_q;
  assign stop      = own_fault | ext_q;
  assign clr_lo    = ~enable_undervoltage_input;
  assign post_core = (state_q != pss_pkg::ST_CORE);
  // faults that a restart command cannot clear
  assign keep      = ssd_q | core_q;
  assign leave     = restart_q & ~keep;

  always_comb begin
    unique case (dly_sel_q)
      2'h0: dly_cyc = 32'h0;
      2'h1: dly_cyc = 32'(DLY1_CYC - 1);
      2'h2: dly_cyc = 32'(DLY2_CYC - 1);
      2'h3: dly_cyc = 32'(DLY3_CYC - 1);
    endcase
  end

  // sequencer next state
  always_comb begin
    state_d = state_q;
    cnt_d   = (cnt_q != 32'h0) ? cnt_q - 32'h1 : 32'h0;
    unique case (state_q)
      pss_pkg::ST_CORE: begin
        if (core_undervoltage) begin
          cnt_d = 32'(CORE_CYC - 1);
        end else if (cnt_q == 32'h0) begin
          state_d = pss_pkg::ST_ADDR;
          cnt_d   = 32'(ADDR_CYC - 1);
        end
      end
      pss_pkg::ST_ADDR: begin
        if (cnt_q == 32'h0) begin
          state_d = pss_pkg::ST_EN_WAIT;
        end
      end
      pss_pkg::ST_EN_WAIT: begin
        if (enable_undervoltage_input && !boost_undervoltage) begin
          state_d = pss_pkg::ST_DELAY;
          cnt_d   = dly_cyc;
        end
      end
      pss_pkg::ST_DELAY: begin
        if (cnt_q == 32'h0) begin
          state_d = pss_pkg::ST_CHECK;
          cnt_d   = 32'(CHECK_CYC - 1);
        end
      end
      pss_pkg::ST_CHECK: begin
        if (check_end && vout_low && ss_cap_below_threshold) begin
          state_d = pss_pkg::ST_RAMP;
        end
      end
      pss_pkg::ST_RAMP: begin
        if (ramp_done) begin
          state_d = pss_pkg::ST_PG_WAIT;
          cnt_d   = 32'(PG_CYC - 1);
        end
      end
      pss_pkg::ST_PG_WAIT: begin
        if (cnt_q == 32'h0) begin
          state_d = pss_pkg::ST_RUN;
        end
      end
      pss_pkg::ST_RUN: begin
      end
      pss_pkg::ST_FAULT: begin
        if (leave) begin
          state_d = pss_pkg::ST_EN_WAIT;
        end
      end
      default: begin
        state_d = pss_pkg::ST_CORE;
      end
    endcase
    if (post_core && state_q != pss_pkg::ST_ADDR) begin
      if (stop && !(state_q == pss_pkg::ST_FAULT && leave)) begin
        state_d = pss_pkg::ST_FAULT;
      end else if (clr_lo && state_q != pss_pkg::ST_EN_WAIT) begin
        state_d = pss_pkg::ST_EN_WAIT;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= pss_pkg::ST_CORE;
      cnt_q   <= 32'(CORE_CYC - 1);
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // latched faults, a set wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_q <= 1'b0;
      ssd_q   <= 1'b0;
      moderate_limit_resistor_pin_q  <= 1'b0;
      addr_q  <= 1'b0;
      core_q  <= 1'b0;
      ext_q   <= 1'b0;
    end else begin
      short_q <= (check_end & ~vout_low) |
                 (short_q & ~(clr_lo | restart_q));
      ssd_q   <= (check_end & ~ss_cap_below_threshold) |
                 (ssd_q & ~clr_lo);
      moderate_limit_resistor_pin_q  <= (post_core & limit_resistor_bad) |
                 (moderate_limit_resistor_pin_q & ~(clr_lo | restart_q));
      addr_q  <= (state_q == pss_pkg::ST_ADDR && cnt_q == 32'h0 &&
                  !address_resistor_ok) |
                 (addr_q & ~(clr_lo | restart_q));
      core_q  <= (post_core & core_undervoltage) | core_q;
      ext_q   <= (~fault_line_i & ~own_fault) |
                 (ext_q & ~(clr_lo | restart_q));
    end
  end

  // address decode completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_done_q <= 1'b0;
    end else begin
      if (state_q == pss_pkg::ST_ADDR && cnt_q == 32'h0) begin
        addr_done_q <= 1'b1;
      end
    end
  end

  // current hysteresis flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hyst_q <= 1'b0;
    end else if (current_above_upper) begin
      hyst_q <= 1'b1;
    end else if (current_below_lower) begin
      hyst_q <= 1'b0;
    end
  end

  // power good
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_q <= 1'b0;
    end else begin
      pg_q <= (state_d == pss_pkg::ST_RUN);
    end
  end

  // power stage drive
  assign pass_switch_on = (state_q == pss_pkg::ST_RAMP ||
                           state_q == pss_pkg::ST_PG_WAIT ||
                           state_q == pss_pkg::ST_RUN) && !stop;
  assign output_discharge_en = (state_q == pss_pkg::ST_CHECK);
  assign ss_discharge_en     = (state_q == pss_pkg::ST_CHECK);
  assign ss_charge_en        = pass_switch_on;
  assign power_good_output   = pg_q;

  assign address_select_pin_o  = hyst_q;
  assign address_select_pin_oe = addr_done_q;
  assign fault_line_o  = 1'b0;
  assign fault_line_oe = own_fault;
  assign bus_alert_o   = 1'b0;
  assign bus_alert_oe  = stop;

  // apb slave, no wait states
  assign wr       = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready   = psel & penable;
  assign pslverr  = pready && paddr != pss_pkg::OFS_CTRL &&
                    paddr != pss_pkg::OFS_STATUS;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_sel_q <= pss_pkg::DLY_SEL_RST;
      thr_sel_q <= pss_pkg::THR_SEL_RST;
      restart_q <= 1'b0;
    end else begin
      restart_q <= 1'b0;
      if (wr && paddr == pss_pkg::OFS_CTRL) begin
        dly_sel_q <= pwdata[pss_pkg::CTRL_DLY_LSB +: 2];
        thr_sel_q <= pwdata[pss_pkg::CTRL_THR_LSB +: 2];
        restart_q <= pwdata[pss_pkg::CTRL_RESTART];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_setup) begin
      prdata <= 32'h0;
      if (paddr == pss_pkg::OFS_CTRL) begin
        prdata[pss_pkg::CTRL_DLY_LSB +: 2] <= dly_sel_q;
        prdata[pss_pkg::CTRL_THR_LSB +: 2] <= thr_sel_q;
      end else if (paddr == pss_pkg::OFS_STATUS) begin
        prdata[pss_pkg::ST_STATE_LSB +: 4] <= state_q;
        prdata[pss_pkg::ST_FLT_LSB +: 6] <=
          {ext_q, core_q, addr_q, moderate_limit_resistor_pin_q, ssd_q, short_q};
        prdata[pss_pkg::ST_PG]        <= pg_q;
        prdata[pss_pkg::ST_HYST]      <= hyst_q;
        prdata[pss_pkg::ST_ADDR_DONE] <= addr_done_q;
      end
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_core_hold;
    state_q == pss_pkg::ST_CORE && core_undervoltage |=>
      state_q == pss_pkg::ST_CORE && cnt_q == 32'(CORE_CYC - 1);
  endproperty
  a_core_hold: assert property (p_core_hold)
    else $error("left core wait during undervoltage");

  property p_addr_ignore;
    state_q == pss_pkg::ST_ADDR && cnt_q != 32'h0 |=>
      state_q == pss_pkg::ST_ADDR && !pass_switch_on;
  endproperty
  a_addr_ignore: assert property (p_addr_ignore)
    else $error("address phase cut short");

  property p_short;
    check_end && !vout_low |=> short_q && fault_line_oe ##1 !pg_q;
  endproperty
  a_short: assert property (p_short)
    else $error("short not latched");

  property p_pass;
    check_end && vout_low && ss_cap_below_threshold && !stop &&
      enable_undervoltage_input |=> state_q == pss_pkg::ST_RAMP;
  endproperty
  a_pass: assert property (p_pass)
    else $error("passed check did not ramp");

  property p_ssd;
    check_end && !ss_cap_below_threshold |=>
      ssd_q && fault_line_oe ##1 !pass_switch_on;
  endproperty
  a_ssd: assert property (p_ssd)
    else $error("cap discharge fault missed");

  property p_ssd_cmd;
    ssd_q && restart_q && enable_undervoltage_input |=> ssd_q;
  endproperty
  a_ssd_cmd: assert property (p_ssd_cmd)
    else $error("cap fault cleared by command");

  property p_ramp_after;
    ss_charge_en && !$past(ss_charge_en) |->
      $past(state_q) == pss_pkg::ST_CHECK;
  endproperty
  a_ramp_after: assert property (p_ramp_after)
    else $error("ramp without self-check");

  property p_hyst;
    !current_above_upper && !current_below_lower |=>
      $stable(hyst_q);
  endproperty
  a_hyst: assert property (p_hyst)
    else $error("flag moved inside band");

  property p_fault_pin;
    own_fault |-> fault_line_oe && !fault_line_o && !pass_switch_on;
  endproperty
  a_fault_pin: assert property (p_fault_pin)
    else $error("fault line not low");

  property p_en_low;
    state_q == pss_pkg::ST_RUN && !enable_undervoltage_input |=>
      !pass_switch_on ##1 !power_good_output;
  endproperty
  a_en_low: assert property (p_en_low)
    else $error("disable not honoured");

  property p_core_latch;
    post_core && core_undervoltage |=> core_q [*3];
  endproperty
  a_core_latch: assert property (p_core_latch)
    else $error("core fault not latched");

  c_run: cover property (state_q == pss_pkg::ST_RUN);
  c_short: cover property (check_end && !vout_low);
  c_restart: cover property (state_q == pss_pkg::ST_FAULT && restart_q);
endmodule

//--- verification/pss_far_model.sv
// power stage and pin wiring model on the far side of the sequencer
`timescale 1ns/1ps
module pss_far_model (
  // clock
  input  wire logic       pclk,
  // stage controls from the sequencer
  input  wire logic       output_discharge_en,
  input  wire logic       ss_discharge_en,
  input  wire logic       ss_charge_en,
  // pin drivers from the sequencer
  input  wire logic       fault_line_o,
  input  wire logic       fault_line_oe,
  input  wire logic       address_select_pin_o,
  input  wire logic       address_select_pin_oe,
  // scenario knobs
  input  wire logic [1:0] vout_floor,
  input  wire logic       cap_stuck,
  input  wire logic       ext_pull,
  // levels seen by the sequencer
  output logic [2:0]      output_below_check_threshold,
  output logic            ss_cap_below_threshold,
  output logic            ramp_done,
  output logic            fault_line_i,
  output logic            address_select_pin_i
);
  logic [1:0] vout_q = 2'h3;
  logic       cap_q  = 1'b1;
  // output level: discharge to floor, ramp while charging
  always @(posedge pclk) begin
    if (output_discharge_en) begin
      vout_q <= vout_floor;
    end else if (ss_charge_en && vout_q != 2'h3) begin
      vout_q <= vout_q + 2'h1;
    end
  end
  // soft-start cap, stuck high when asked
  always @(posedge pclk) begin
    if (ss_discharge_en && !cap_stuck) begin
      cap_q <= 1'b0;
    end else if (ss_charge_en) begin
      cap_q <= 1'b1;
    end
  end
  assign output_below_check_threshold[0] = vout_q <= 2'h0;
  assign output_below_check_threshold[1] = vout_q <= 2'h1;
  assign output_below_check_threshold[2] = vout_q <= 2'h2;
  assign ss_cap_below_threshold = !cap_q;
  assign ramp_done = ss_charge_en && vout_q == 2'h3;
  // pulled-up fault line, pulled-down address pin
  assign fault_line_i = !((fault_line_oe && !fault_line_o) || ext_pull);
  assign address_select_pin_i = address_select_pin_oe && address_select_pin_o;
endmodule

//--- verification/tb_protection_startup_sequencer.sv
// self-checking bench for the startup sequencer
`timescale 1ns/1ps
module tb_protection_startup_sequencer;
  localparam int unsigned D1 = 4;
  localparam int unsigned D2 = 6;
  localparam int unsigned D3 = 8;
  localparam int unsigned DX [4] = '{3, D1 + 2, D2 + 2, D3 + 2};
  logic        pclk, pready, pslverr, pass_switch_on, ramp_done;
  logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rnd = 32'h2abc;
  logic        core_undervoltage = 1'b1, boost_undervoltage = 1'b0;
  logic        enable_undervoltage_input = 1'b1, address_resistor_ok = 1'b1;
  logic        limit_resistor_bad = 1'b0, current_above_upper = 1'b0;
  logic        current_below_lower = 1'b0, cap_stuck = 1'b0, ext_pull = 1'b0;
  logic [1:0]  vout_floor = 2'h0;
  logic [2:0]  output_below_check_threshold;
  logic        ss_cap_below_threshold, output_discharge_en, ss_discharge_en;
  logic        ss_charge_en, power_good_output, address_select_pin_i;
  logic        address_select_pin_o, address_select_pin_oe, fault_line_i;
  logic        fault_line_o, fault_line_oe, bus_alert_o, bus_alert_oe;
  logic        ode_q = 1'b0, hy = 1'b0;
  logic [37:0] q_rd [$];
  int          q_dly [$];
  int          n_mismatch = 0, total_checks = 0, cyc = 0, en_cyc = 0;

  pss_sequencer #(.CORE_CYC(8), .ADDR_CYC(6), .CHECK_CYC(10), .PG_CYC(12),
    .DLY1_CYC(D1), .DLY2_CYC(D2), .DLY3_CYC(D3)) dut (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .core_undervoltage, .boost_undervoltage, .enable_undervoltage_input,
    .address_resistor_ok, .limit_resistor_bad, .output_below_check_threshold,
    .ss_cap_below_threshold, .ramp_done, .current_above_upper,
    .current_below_lower, .pass_switch_on, .output_discharge_en,
    .ss_discharge_en, .ss_charge_en, .power_good_output,
    .address_select_pin_i, .address_select_pin_o, .address_select_pin_oe,
    .fault_line_i, .fault_line_o, .fault_line_oe, .bus_alert_o, .bus_alert_oe);

  pss_far_model far (.pclk, .output_discharge_en, .ss_discharge_en,
    .ss_charge_en, .fault_line_o, .fault_line_oe, .address_select_pin_o,
    .address_select_pin_oe, .vout_floor, .cap_stuck, .ext_pull,
    .output_below_check_threshold, .ss_cap_below_threshold, .ramp_done,
    .fault_line_i, .address_select_pin_i);

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // {alert, id pin, pg pin, fault_oe, pass, slverr, status word}
  function automatic logic [37:0] ex(input pss_pkg::pss_state_e st,
      input logic [5:0] f, input logic pg, input logic fo);
    return {|f, hy, pg, fo, pg, 1'b0, 13'h0, 1'b1, hy, pg, 2'h0, f, 4'h0,
            st};
  endfunction

  task automatic complete_run;
    if (n_mismatch == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic cmp_rd(input logic [37:0] e, input logic [37:0] a);
    total_checks++;
    if (a !== e) begin
      n_mismatch++;
      $display("[ERR] %0t exp %h got %h", $time, e, a);
    end
  endtask

  task automatic cmp_dly(input int e, input int a);
    total_checks++;
    if (a != e) begin
      n_mismatch++;
      $display("[ERR] %0t exp %h got %h", $time, e, a);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      n_mismatch++;
      complete_run;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [37:0] e,
      input logic [7:0] a = pss_pkg::OFS_STATUS);
    q_rd.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // reserved and spare bits carry random filler
  task automatic wr(input logic [31:0] d);
    rnd = lfsr(rnd);
    apb(1'b1, pss_pkg::OFS_CTRL, {rnd[31:9], d[8], rnd[7:4], d[3:0]});
  endtask

  task automatic rf(input logic [5:0] f, input logic fo);
    rd(ex(pss_pkg::ST_FAULT, f, 1'b0, fo));
  endtask

  // wait for power good or own fault, then read back the run status if ok
  task automatic up(input logic ok);
    int n;
    n = 0;
    // let a cleared fault drop before looking
    repeat (2) @(posedge pclk);
    while (power_good_output !== 1'b1 && fault_line_oe !== 1'b1) begin
      @(negedge pclk);
      n++;
      if (n > 400) begin
        n_mismatch++;
        complete_run;
      end
    end
    if (ok)
      rd(ex(pss_pkg::ST_RUN, 6'h0, 1'b1, 1'b0));
  endtask

  task automatic toggle;
    @(posedge pclk);
    enable_undervoltage_input <= 1'b0;
    repeat (3) @(posedge pclk);
    enable_undervoltage_input <= 1'b1;
    en_cyc = cyc;
  endtask

  // result watcher
  always @(negedge pclk) begin
    cyc++;
    if (psel && penable && pready && !pwrite && q_rd.size() > 0)
      cmp_rd(q_rd.pop_front(), {bus_alert_oe & ~bus_alert_o,
        address_select_pin_i, power_good_output, fault_line_oe,
        pass_switch_on, pslverr, prdata});
    if (output_discharge_en && !ode_q && q_dly.size() > 0)
      cmp_dly(q_dly.pop_front(), cyc - en_cyc);
    ode_q = output_discharge_en;
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (20) @(posedge pclk);
    rd(38'h0);
    rd({6'b000001, 32'h0}, 8'h08);
    rd({6'b000000, 32'h8}, pss_pkg::OFS_CTRL);
    boost_undervoltage <= 1'b1;
    core_undervoltage <= 1'b0;
    repeat (30) @(posedge pclk);
    rd(ex(pss_pkg::ST_EN_WAIT, 6'h0, 1'b0, 1'b0));
    boost_undervoltage <= 1'b0;
    up(1'b1);
    current_above_upper <= 1'b1;
    hy = 1'b1;
    rd(ex(pss_pkg::ST_RUN, 6'h0, 1'b1, 1'b0));
    current_above_upper <= 1'b0;
    rd(ex(pss_pkg::ST_RUN, 6'h0, 1'b1, 1'b0));
    current_below_lower <= 1'b1;
    hy = 1'b0;
    rd(ex(pss_pkg::ST_RUN, 6'h0, 1'b1, 1'b0));
    current_below_lower <= 1'b0;
    vout_floor <= 2'h1;
    for (int i = 0; i < 4; i++) begin
      wr({28'h0, 2'(3 - i), 2'(i)});
      q_dly.push_back(DX[i]);
      toggle;
      up(1'b0);
      if (i < 3)
        rd(ex(pss_pkg::ST_RUN, 6'h0, 1'b1, 1'b0));
      else
        rf(6'h01, 1'b1);
    end
    vout_floor <= 2'h0;
    wr(32'h108);
    up(1'b1);
    cap_stuck <= 1'b1;
    toggle;
    up(1'b0);
    rf(6'h02, 1'b1);
    wr(32'h108);
    rf(6'h02, 1'b1);
    cap_stuck <= 1'b0;
    toggle;
    up(1'b1);
    limit_resistor_bad <= 1'b1;
    repeat (2) @(posedge pclk);
    limit_resistor_bad <= 1'b0;
    rf(6'h04, 1'b1);
    wr(32'h108);
    up(1'b1);
    ext_pull <= 1'b1;
    repeat (2) @(posedge pclk);
    rf(6'h20, 1'b0);
    ext_pull <= 1'b0;
    toggle;
    up(1'b1);
    core_undervoltage <= 1'b1;
    repeat (2) @(posedge pclk);
    rf(6'h10, 1'b1);
    core_undervoltage <= 1'b0;
    wr(32'h108);
    rf(6'h10, 1'b1);
    presetn <= 1'b0;
    address_resistor_ok <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    up(1'b0);
    rf(6'h08, 1'b1);
    if (q_dly.size() != 0 || q_rd.size() != 0)
      n_mismatch++;
    complete_run;
  end
endmodule
